// [core/uab_consts.svh]
// constants for the autobaud measurement block: offsets, fields, resets, counts
// assumes it is included by bare name into each design file that needs it
`ifndef UAB_CONSTS_SVH
`define UAB_CONSTS_SVH

// register offsets on the plain port
`define UAB_OFS_CTRL 3'h0
`define UAB_OFS_DIV_LO 3'h1
`define UAB_OFS_DIV_HI 3'h2
`define UAB_OFS_RXDATA 3'h3
`define UAB_OFS_IRQ_STAT 3'h4
`define UAB_OFS_IRQ_MASK 3'h5
`define UAB_OFS_FLAGS 3'h6

// control register fields
`define UAB_CTRL_ARM 0
`define UAB_CTRL_WAKE 1
`define UAB_CTRL_WIDE 2
`define UAB_CTRL_HSPD 3
`define UAB_CTRL_BUSY 7

// interrupt status fields
`define UAB_IRQ_DONE 0
`define UAB_IRQ_OVF 1
`define UAB_IRQ_W 2

// flags register field
`define UAB_FLAG_RX 0

// reset values
`define UAB_RST_BYTE 8'h00
`define UAB_RST_DIV 16'h0000
`define UAB_RST_IRQ 2'h0
`define UAB_RXDATA_VAL 8'h00

// measurement figures
`define UAB_CNT_PRESET 16'h0001
`define UAB_CNT_MAX 16'hffff
`define UAB_EDGES_AFTER_FIRST 3'h4
`define UAB_DIV_SLOW 10'h200
`define UAB_DIV_MID 10'h080
`define UAB_DIV_FAST 10'h020
`define UAB_DIV_ONE 10'h001

`endif

// [core/uab_pkg.sv]
// types shared by the autobaud measurement files
// assumes the constants header is compiled alongside
package uab_pkg;

  // measurement sequencer states, one-hot
  typedef enum logic [5:0] {
    UAB_ST_IDLE = 6'b000001,
    UAB_ST_BRK_LOW = 6'b000010,
    UAB_ST_BRK_END = 6'b000100,
    UAB_ST_START = 6'b001000,
    UAB_ST_EDGE1 = 6'b010000,
    UAB_ST_COUNT = 6'b100000
  } uab_state_t;

endpackage

// [core/uab_tick.sv]
// measurement clock enable generator
// assumes one system clock; restart aligns the divider to a line edge
`timescale 1ns/10ps
`include "uab_consts.svh"

module uab_tick (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // control
  input wire logic restart,
  input wire logic wide_sel,
  input wire logic hspd_sel,
  // enable pulse out
  output logic tick
);

  logic [9:0] cnt_r;
  logic [9:0] div;

  // divide ratio from the two rate bits
  function automatic logic [9:0] uab_div(input logic wide, input logic hspd);
    logic [9:0] d;
    d = `UAB_DIV_MID;
    if (!wide && !hspd)
      d = `UAB_DIV_SLOW;
    else if (wide && hspd)
      d = `UAB_DIV_FAST;
    return d;
  endfunction

  assign div = uab_div(wide_sel, hspd_sel);

  // free counter, pulse one cycle at terminal count
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= 10'h000;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      if (restart)
      begin
        cnt_r <= 10'h000;
        tick <= 1'b0;
      end
      else if (cnt_r == div - `UAB_DIV_ONE)
      begin
        cnt_r <= 10'h000;
        tick <= 1'b1;
      end
      else
      begin
        cnt_r <= cnt_r + `UAB_DIV_ONE;
        tick <= 1'b0;
      end
    end
  end

endmodule

// [core/uab_autobaud.sv]
// autobaud measurement block with its register port and interrupt
// assumes rx is synchronous to clk_sys and idles high
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "uab_consts.svh"

module uab_autobaud (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_r,
  // serial line
  input wire logic rx,
  // to the receiver and rate generator
  output logic rx_hold_idle_r,
  output logic receive_flag_r,
  output logic [15:0] rate_divisor_r,
  // interrupt
  output logic irq_r
);

  uab_pkg::uab_state_t state_r;
  uab_pkg::uab_state_t state_nxt;
  logic autobaud_arm_r;
  logic wake_on_break_enable_r;
  logic wide_divisor_select_r;
  logic high_speed_select_r;
  logic [7:0] rate_divisor_low_r;
  logic [7:0] rate_divisor_high_r;
  logic [`UAB_IRQ_W-1:0] irq_stat_r;
  logic [`UAB_IRQ_W-1:0] irq_mask_r;
  logic [2:0] edge_cnt_r;
  logic rx_d_r;
  logic rise;
  logic fall;
  logic tick;
  logic rate_measure_mode;
  logic arm_set;
  logic arm_clr_sw;
  logic begin_seq;
  logic done;
  logic ovf;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic rd_rxdata;
  logic wr_stat;
  logic wr_mask;
  logic counting;
  logic [15:0] pair;

  // line edges against the previous sample
  assign rise = rx & ~rx_d_r;
  assign fall = ~rx & rx_d_r;

  // strobe aimed at one register offset, shared by every decode below
  function automatic logic uab_hit(input logic strobe, input logic [2:0] addr,
    input logic [2:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  // bus decodes
  assign wr_ctrl = uab_hit(reg_wr, reg_addr, `UAB_OFS_CTRL);
  assign wr_lo = uab_hit(reg_wr, reg_addr, `UAB_OFS_DIV_LO);
  assign wr_hi = uab_hit(reg_wr, reg_addr, `UAB_OFS_DIV_HI);
  assign wr_stat = uab_hit(reg_wr, reg_addr, `UAB_OFS_IRQ_STAT);
  assign wr_mask = uab_hit(reg_wr, reg_addr, `UAB_OFS_IRQ_MASK);
  assign rd_rxdata = uab_hit(reg_rd, reg_addr, `UAB_OFS_RXDATA);
  // a second arm write while armed must not restart a running measurement
  assign arm_set = wr_ctrl && reg_wdata[`UAB_CTRL_ARM] && !autobaud_arm_r;
  assign arm_clr_sw = wr_ctrl && !reg_wdata[`UAB_CTRL_ARM];

  // measurement is under way while the sequencer is away from idle
  assign rate_measure_mode = (state_r != uab_pkg::UAB_ST_IDLE);
  assign begin_seq = arm_set;
  // counting phase and the divisor pair seen as one word
  assign counting = (state_r == uab_pkg::UAB_ST_COUNT);
  assign pair = {rate_divisor_high_r, rate_divisor_low_r};
  assign done = counting && rise &&
                (edge_cnt_r == `UAB_EDGES_AFTER_FIRST - 3'h1);
  // the pair wraps to zero; the status bit tells software the count is useless
  assign ovf = counting && tick && (pair == `UAB_CNT_MAX);

  // previous line sample, idle high
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rx_d_r <= 1'b1;
    else if (ce)
      rx_d_r <= rx;
  end

  // sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      uab_pkg::UAB_ST_IDLE:
      begin
        if (begin_seq)
        begin
          if (reg_wdata[`UAB_CTRL_WAKE])
            state_nxt = uab_pkg::UAB_ST_BRK_LOW;
          else
            state_nxt = uab_pkg::UAB_ST_START;
        end
      end
      uab_pkg::UAB_ST_BRK_LOW:
      begin
        // the line must be seen low first, so an idle line cannot pass as a break end
        if (!rx)
          state_nxt = uab_pkg::UAB_ST_BRK_END; // break in progress
      end
      uab_pkg::UAB_ST_BRK_END:
      begin
        if (rise)
          state_nxt = uab_pkg::UAB_ST_START; // break over, sync follows
      end
      uab_pkg::UAB_ST_START:
      begin
        if (fall)
          state_nxt = uab_pkg::UAB_ST_EDGE1; // start bit of sync
      end
      uab_pkg::UAB_ST_EDGE1:
      begin
        if (rise)
          state_nxt = uab_pkg::UAB_ST_COUNT;
      end
      uab_pkg::UAB_ST_COUNT:
      begin
        if (done)
          state_nxt = uab_pkg::UAB_ST_IDLE;
      end
      default:
        state_nxt = uab_pkg::UAB_ST_IDLE;
    endcase
    // software clearing the arm bit aborts the sequence
    if (arm_clr_sw)
      state_nxt = uab_pkg::UAB_ST_IDLE;
  end

  // sequencer state
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= uab_pkg::UAB_ST_IDLE;
    else if (ce)
      state_r <= state_nxt;
  end

  // rising edges seen after the first one
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      edge_cnt_r <= 3'h0;
    else if (ce)
    begin
      // three counted edges plus the one now seen make the fifth
      if (!counting)
        edge_cnt_r <= 3'h0;
      else if (rise)
        edge_cnt_r <= edge_cnt_r + 3'h1;
    end
  end

  // measure clock, realigned at the first rising edge
  uab_tick u_tick (
    .clk_sys (clk_sys),
    .rst_b (rst_b),
    .ce (ce),
    // held at zero until counting, so the first step lands one full period later
    .restart (!counting),
    .wide_sel (wide_divisor_select_r),
    .hspd_sel (high_speed_select_r),
    .tick (tick)
  );

  // control bits; hardware clear of the arm bit wins over a write
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      autobaud_arm_r <= 1'b0;
      wake_on_break_enable_r <= 1'b0;
      wide_divisor_select_r <= 1'b0;
      high_speed_select_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_ctrl)
      begin
        autobaud_arm_r <= reg_wdata[`UAB_CTRL_ARM];
        wake_on_break_enable_r <= reg_wdata[`UAB_CTRL_WAKE];
        wide_divisor_select_r <= reg_wdata[`UAB_CTRL_WIDE];
        high_speed_select_r <= reg_wdata[`UAB_CTRL_HSPD];
      end
      if (done)
        autobaud_arm_r <= 1'b0;
    end
  end

  // divisor pair: software bytes when idle, one 16-bit counter when measuring
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rate_divisor_low_r <= `UAB_RST_BYTE;
      rate_divisor_high_r <= `UAB_RST_BYTE;
    end
    else if (ce)
    begin
      if (begin_seq)
      begin
        rate_divisor_high_r <= 8'(`UAB_CNT_PRESET >> 8);
        rate_divisor_low_r <= 8'(`UAB_CNT_PRESET);
      end
      else if (rate_measure_mode)
      begin
        // no step on the completing edge, so the count covers exactly eight bit times
        if (counting && tick && !done)
          {rate_divisor_high_r, rate_divisor_low_r} <=
            pair + `UAB_CNT_PRESET;
      end
      else
      begin
        // count left in place after completion, only software changes it
        if (wr_lo)
          rate_divisor_low_r <= reg_wdata;
        if (wr_hi)
          rate_divisor_high_r <= reg_wdata;
      end
    end
  end

  // receive flag: set by completion, cleared by a data read, set wins
  // so a completion landing on a read of the data register is never lost
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      receive_flag_r <= 1'b0;
    else if (ce)
    begin
      if (done)
        receive_flag_r <= 1'b1;
      else if (rd_rxdata)
        receive_flag_r <= 1'b0;
    end
  end

  // receiver hold while measuring
  // taken from the next state so the hold rises together with the busy bit
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rx_hold_idle_r <= 1'b0;
    else if (ce)
      rx_hold_idle_r <= (state_nxt != uab_pkg::UAB_ST_IDLE);
  end

  // divisor to the rate generator, copied from the pair whenever the sequencer is idle
  // frozen while measuring; after an abort the preset or partial count reaches the generator
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rate_divisor_r <= `UAB_RST_DIV;
    else if (ce && !rate_measure_mode)
      rate_divisor_r <= pair;
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_stat_r <= `UAB_RST_IRQ;
    else if (ce)
    begin
      if (wr_stat)
        irq_stat_r <= irq_stat_r & ~reg_wdata[`UAB_IRQ_W-1:0];
      if (done)
        irq_stat_r[`UAB_IRQ_DONE] <= 1'b1;
      if (ovf)
        irq_stat_r[`UAB_IRQ_OVF] <= 1'b1;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_mask_r <= `UAB_RST_IRQ;
    else if (ce && wr_mask)
      irq_mask_r <= reg_wdata[`UAB_IRQ_W-1:0];
  end

  // interrupt line from registered status and mask
  // one cycle behind the status, since every top output comes from a flip-flop
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_r <= 1'b0;
    else if (ce)
      irq_r <= |(irq_stat_r & irq_mask_r);
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata_r <= `UAB_RST_BYTE;
    else if (ce)
    begin
      reg_rdata_r <= `UAB_RST_BYTE;
      if (reg_rd)
      begin
        case (reg_addr)
          `UAB_OFS_CTRL:
          begin
            reg_rdata_r[`UAB_CTRL_ARM] <= autobaud_arm_r;
            reg_rdata_r[`UAB_CTRL_WAKE] <= wake_on_break_enable_r;
            reg_rdata_r[`UAB_CTRL_WIDE] <= wide_divisor_select_r;
            reg_rdata_r[`UAB_CTRL_HSPD] <= high_speed_select_r;
            reg_rdata_r[`UAB_CTRL_BUSY] <= rate_measure_mode;
          end
          `UAB_OFS_DIV_LO:
            reg_rdata_r <= rate_divisor_low_r;
          `UAB_OFS_DIV_HI:
            reg_rdata_r <= rate_divisor_high_r; // zero means low byte held the count
          `UAB_OFS_RXDATA:
            reg_rdata_r <= `UAB_RXDATA_VAL; // content is meaningless
          `UAB_OFS_IRQ_STAT:
            reg_rdata_r[`UAB_IRQ_W-1:0] <= irq_stat_r;
          `UAB_OFS_IRQ_MASK:
            reg_rdata_r[`UAB_IRQ_W-1:0] <= irq_mask_r;
          `UAB_OFS_FLAGS:
            reg_rdata_r[`UAB_FLAG_RX] <= receive_flag_r;
          default:
            reg_rdata_r <= `UAB_RST_BYTE;
        endcase
      end
    end
  end

endmodule

// [test/uab_autobaud_checker.sv]
// concurrent checks on the autobaud block ports
// assumes one clock, rx synchronous to clk_sys; bound to every uab_autobaud
`timescale 1ns/10ps
`include "uab_consts.svh"

module uab_autobaud_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_r,
  // line and results
  input wire logic rx,
  input wire logic rx_hold_idle_r,
  input wire logic receive_flag_r,
  input wire logic [15:0] rate_divisor_r
);
  logic rx_q_r;
  logic [2:0] rise_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // rising edges of rx seen while a measurement is held open
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_q_r <= 1'b1;
      rise_r <= 3'h0;
    end
    else
    begin
      rx_q_r <= rx;
      if (!rx_hold_idle_r)
        rise_r <= 3'h0;
      else if (rx && !rx_q_r)
        rise_r <= rise_r + 3'h1;
    end
  end

  a_arm_holds_idle: assert property (ce && reg_wr && reg_addr == `UAB_OFS_CTRL
    && reg_wdata[`UAB_CTRL_ARM] && !rx_hold_idle_r |=> rx_hold_idle_r)
    else $error("arm write did not start a measurement");
  a_busy_readback: assert property (reg_rd && reg_addr == `UAB_OFS_CTRL
    |=> reg_rdata_r[`UAB_CTRL_BUSY] == $past(rx_hold_idle_r))
    else $error("busy bit does not match measurement state");
  a_done_ends_hold: assert property ($rose(receive_flag_r) |-> $fell(rx_hold_idle_r))
    else $error("receive flag rose without the measurement ending");
  a_done_on_rise: assert property ($rose(receive_flag_r) |-> $past(rx) && !$past(rx, 2))
    else $error("measurement ended away from a rising edge");
  a_edge_count: assert property ($rose(receive_flag_r) |-> rise_r == 3'h5 || rise_r == 3'h6)
    else $error("measurement ended after a wrong number of edges");
  a_flag_clear: assert property (ce && receive_flag_r && reg_rd
    && reg_addr == `UAB_OFS_RXDATA && !rx_hold_idle_r |=> !receive_flag_r)
    else $error("receive data read left the flag set");
  a_flag_sticky: assert property (receive_flag_r
    && !(reg_rd && reg_addr == `UAB_OFS_RXDATA) |=> receive_flag_r)
    else $error("receive flag dropped without a data read");
  a_rxdata_value: assert property (reg_rd && reg_addr == `UAB_OFS_RXDATA
    |=> reg_rdata_r == `UAB_RXDATA_VAL)
    else $error("receive data register value wrong");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
    else $error("read data outside the read answer cycle");
  a_div_frozen: assert property (rx_hold_idle_r && $past(rx_hold_idle_r)
    && $past(rx_hold_idle_r, 2) |-> $stable(rate_divisor_r))
    else $error("divisor output moved during measurement");
endmodule

bind uab_autobaud uab_autobaud_checker chk_i (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r), .rx(rx), .rx_hold_idle_r(rx_hold_idle_r),
  .receive_flag_r(receive_flag_r), .rate_divisor_r(rate_divisor_r));

// [test/uab_sync_tx.sv]
// remote transmitter model: optional break, then one sync character
// assumes it is clocked by clk_sys; the line idles high as with a pull-up
`timescale 1ns/10ps

module uab_sync_tx (
  // clock
  input wire logic clk_sys,
  // command
  input wire logic go,
  input wire logic brk,
  input wire logic [15:0] bit_cyc,
  // line
  output logic rx,
  output logic tx_busy
);
  logic [9:0] frame;
  int i;

  initial
  begin
    rx = 1'b1;
    tx_busy = 1'b0;
  end

  // start bit, sync byte lsb first, stop bit; a break is held low first
  always @(posedge clk_sys)
  begin
    if (go)
    begin
      tx_busy <= 1'b1;
      frame = {1'b1, 8'h55, 1'b0};
      if (brk)
      begin
        rx <= 1'b0;
        repeat (11 * bit_cyc) @(posedge clk_sys);
        rx <= 1'b1;
        repeat (bit_cyc) @(posedge clk_sys);
      end
      for (i = 0; i < 10; i++)
      begin
        rx <= frame[i];
        repeat (bit_cyc) @(posedge clk_sys);
      end
      tx_busy <= 1'b0;
    end
  end
endmodule

// [test/test_uab_autobaud.sv]
// self-checking bench for the autobaud block with a sync transmitter
// assumes the design, its header and the checker are compiled first
`timescale 1ns/10ps
`include "uab_consts.svh"

module test_uab_autobaud;
  logic clk_sys, rst_b, ce, reg_wr, reg_rd, rx, go, brk, tx_busy, hold, flag, irq;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, rdata;
  logic [15:0] bit_cyc, div;
  int err_total, num_checks, seed, a, m;
  int exp_q[$];

  uab_autobaud dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata), .rx(rx),
    .rx_hold_idle_r(hold), .receive_flag_r(flag), .rate_divisor_r(div), .irq_r(irq));
  uab_sync_tx tx (.clk_sys(clk_sys), .go(go), .brk(brk), .bit_cyc(bit_cyc), .rx(rx),
    .tx_busy(tx_busy));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_port(input logic [15:0] got, input logic [15:0] e);
    num_checks++;
    if (got !== e)
    begin
      err_total++;
      $display("Error at %0t: port got %0h want %0h", $time, got, e);
    end
  endtask

  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // one read cycle, answer taken in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] ad, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    num_checks++;
    if (rdata !== e)
    begin
      err_total++;
      $display("Error at %0t: read %0h got %0h want %0h", $time, ad, rdata, e);
    end
  endtask

  // one measurement: mode, random rate and mask, optional break
  task automatic run(input int md);
    int d, k, n, e;
    logic [7:0] cfg;
    logic msk;
    d = (md % 4 == 0) ? 512 : (md % 4 == 3) ? 32 : 128;
    k = 2 + $urandom % 8;
    msk = 1'($urandom % 2);
    cfg = {4'h0, md[0], md[1], md == 4, 1'b0};
    exp_q.push_back(1 + k);
    bit_cyc <= 16'(d * (2 * k + 1) / 16);
    wr(`UAB_OFS_IRQ_MASK, {7'h00, msk});
    wr(`UAB_OFS_CTRL, cfg | 8'h01);
    rd_chk(`UAB_OFS_CTRL, cfg | 8'h81);
    chk_port(16'(hold), 16'h0001);
    wr(`UAB_OFS_DIV_LO, 8'hff);
    go <= 1'b1;
    brk <= (md == 4);
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    while (flag !== 1'b1 && n < 30000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 30000)
    begin
      err_total++;
      print_verdict();
    end
    repeat (2) @(posedge clk_sys);
    #1;
    e = exp_q.pop_front();
    chk_port(div, 16'(e));
    chk_port(16'(irq), 16'(msk));
    rd_chk(`UAB_OFS_DIV_LO, 8'(e));
    rd_chk(`UAB_OFS_DIV_HI, 8'(e >> 8));
    wr(`UAB_OFS_DIV_LO, 8'(e - 1));
    rd_chk(`UAB_OFS_DIV_LO, 8'(e - 1));
    chk_port(div, 16'(e - 1));
    rd_chk(`UAB_OFS_CTRL, cfg);
    rd_chk(`UAB_OFS_FLAGS, 8'h01);
    rd_chk(`UAB_OFS_RXDATA, 8'h00);
    rd_chk(`UAB_OFS_FLAGS, 8'h00);
    wr(`UAB_OFS_IRQ_MASK, 8'h01);
    rd_chk(`UAB_OFS_IRQ_STAT, 8'h01);
    chk_port(16'(irq), 16'h0001);
    wr(`UAB_OFS_IRQ_STAT, 8'h01);
    rd_chk(`UAB_OFS_IRQ_STAT, 8'h00);
    chk_port(16'(irq), 16'h0000);
    while (tx_busy === 1'b1) @(posedge clk_sys);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // watchdog on the whole run
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    print_verdict();
  end

  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    brk = 1'b0;
    bit_cyc = 16'h0001;
    err_total = 0;
    num_checks = 0;
    seed = $urandom(6);
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (a = 0; a < 8; a++)
      rd_chk(a[2:0], 8'h00);
    // frozen clock enable: an arm write is ignored
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(`UAB_OFS_CTRL, 8'h01);
    ce <= 1'b1;
    rd_chk(`UAB_OFS_CTRL, 8'h00);
    chk_port(16'(hold), 16'h0000);
    // arm then abort: busy and hold drop, the preset stays in the pair
    wr(`UAB_OFS_CTRL, 8'h01);
    rd_chk(`UAB_OFS_CTRL, 8'h81);
    wr(`UAB_OFS_CTRL, 8'h00);
    rd_chk(`UAB_OFS_CTRL, 8'h00);
    chk_port(16'(hold), 16'h0000);
    rd_chk(`UAB_OFS_DIV_LO, 8'h01);
    chk_port(div, 16'h0001);
    for (m = 0; m < 5; m++)
      run(m);
    print_verdict();
  end
endmodule
